// File: src/loadable_updown_counter.sv
// loadable_updown_counter: loadable binary up/down counter, sync clear
// assumes user logic drives controls synchronously to i_clk
`timescale 1ns/1ps
// What this block does
// - width is a parameter; count, load and flags all scale with it
// - clear high at a clock edge zeroes the count, over everything else
// - during clear with zero count, all-ones reads 0, all-zeros reads 1
// - load high without clear copies load value, ignoring count enables
// - with no clear, load or enables, the count holds
// - up enable alone increments; all-ones flag set when every bit is one
// - down enable alone decrements; all-zeros flag set when all bits zero
// - the count starts at zero
module loadable_updown_counter
  import updown_counter_pkg::*;
#(
  parameter int unsigned WIDTH = COUNT_WIDTH_DEF
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // controls
  input wire logic i_clear,
  input wire logic i_load,
  input wire logic i_count_up_enable,
  input wire logic i_count_down_enable,
  input wire logic [WIDTH-1:0] i_load_data,
  // count and flags
  output logic [WIDTH-1:0] o_count,
  output logic o_all_ones_flag,
  output logic o_all_zeros_flag
);

  localparam logic [WIDTH-1:0] ZERO = {WIDTH{COUNT_RESET_BIT}};
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'h0}}, 1'h1};
  localparam logic [WIDTH-1:0] ONES = '1;

  count_ctrl_t ctrl;
  count_op_t op;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic ones_q;
  logic zeros_q;

  assign ctrl = '{clear: i_clear, load: i_load,
                  count_up_enable: i_count_up_enable,
                  count_down_enable: i_count_down_enable};

  count_op_decode u_decode (
    .i_ctrl(ctrl),
    .o_op(op)
  );

  always_comb begin
    if (i_clear) begin
      count_d = ZERO;
    end else begin
      case (op)
        OP_LOAD: count_d = i_load_data;
        OP_UP: count_d = count_q + ONE;
        OP_DOWN: count_d = count_q - ONE;
        OP_HOLD: count_d = count_q;
        default: count_d = count_q;
      endcase
    end
  end

  // reset gives the zero start state; the flags track it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_q <= ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  // flags registered from the next count so they line up with o_count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ones_q <= 1'h0;
      zeros_q <= 1'h1;
    end else begin
      ones_q <= &count_d;
      zeros_q <= ~|count_d;
    end
  end

  assign o_count = count_q;
  assign o_all_ones_flag = ones_q;
  assign o_all_zeros_flag = zeros_q;

  property p_clear_zero;
    @(posedge i_clk) disable iff (i_rst)
      i_clear |=> (count_q == ZERO) && zeros_q && !ones_q;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("clear did not zero the count");

  property p_clear_flags;
    @(posedge i_clk) disable iff (i_rst)
      i_clear ##1 i_clear |-> !o_all_ones_flag && o_all_zeros_flag;
  endproperty
  a_clear_flags: assert property (p_clear_flags)
    else $error("flags wrong during clear");

  property p_load;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && i_load |=> count_q == $past(i_load_data);
  endproperty
  a_load: assert property (p_load)
    else $error("load value not taken");

  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && !i_load && (i_count_up_enable == i_count_down_enable)
      |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count changed while holding");

  property p_up;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && !i_load && i_count_up_enable && !i_count_down_enable
      |=> count_q == WIDTH'($past(count_q) + ONE);
  endproperty
  a_up: assert property (p_up)
    else $error("count did not increment");

  property p_down;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && !i_load && i_count_down_enable && !i_count_up_enable
      |=> count_q == WIDTH'($past(count_q) - ONE);
  endproperty
  a_down: assert property (p_down)
    else $error("count did not decrement");

  property p_flags_track;
    @(posedge i_clk) disable iff (i_rst)
      (o_all_ones_flag == (&o_count)) && (o_all_zeros_flag == (~|o_count));
  endproperty
  a_flags_track: assert property (p_flags_track)
    else $error("terminal flags disagree with count");

  property p_wrap_up;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && !i_load && i_count_up_enable && !i_count_down_enable
      && (&count_q) ##1 1'b1 |-> count_q == ZERO;
  endproperty
  a_wrap_up: assert property (p_wrap_up)
    else $error("up count did not wrap to zero");

  property p_reset_start;
    @(posedge i_clk) i_rst |=> count_q == ZERO && o_all_zeros_flag;
  endproperty
  a_reset_start: assert property (p_reset_start)
    else $error("count not zero after reset");

  // reset must win over any control still pending from user logic
  property p_reset_over_ctrl;
    @(posedge i_clk)
      i_rst && (i_load || i_count_up_enable || i_count_down_enable)
      |=> o_count == ZERO && !o_all_ones_flag;
  endproperty
  a_reset_over_ctrl: assert property (p_reset_over_ctrl)
    else $error("control beat reset");

  property p_clear_over_load;
    @(posedge i_clk) disable iff (i_rst)
      i_clear && (i_load || i_count_up_enable || i_count_down_enable)
      |=> o_count == ZERO;
  endproperty
  a_clear_over_load: assert property (p_clear_over_load)
    else $error("clear lost to another control");

  property p_load_both;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && i_load && (i_count_up_enable || i_count_down_enable)
      |=> o_count == $past(i_load_data);
  endproperty
  a_load_both: assert property (p_load_both)
    else $error("enables disturbed a load");

  property p_load_flags;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && i_load |=> (o_all_ones_flag == (&$past(i_load_data)))
      && (o_all_zeros_flag == (~|$past(i_load_data)));
  endproperty
  a_load_flags: assert property (p_load_flags)
    else $error("flags wrong after load");

  property p_hold_flags;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && !i_load && !i_count_up_enable && !i_count_down_enable
      |=> $stable(o_all_ones_flag) && $stable(o_all_zeros_flag);
  endproperty
  a_hold_flags: assert property (p_hold_flags)
    else $error("flags moved while holding");

  property p_up_flag;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && !i_load && i_count_up_enable && !i_count_down_enable
      && (count_q == ONES - ONE) |=> o_all_ones_flag && !o_all_zeros_flag;
  endproperty
  a_up_flag: assert property (p_up_flag)
    else $error("all-ones flag not raised");

  property p_down_flag;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && !i_load && i_count_down_enable && !i_count_up_enable
      && (count_q == ONE) |=> o_all_zeros_flag && !o_all_ones_flag;
  endproperty
  a_down_flag: assert property (p_down_flag)
    else $error("all-zeros flag not raised");

  property p_wrap_down;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && !i_load && i_count_down_enable && !i_count_up_enable
      && (count_q == ZERO) |=> count_q == ONES;
  endproperty
  a_wrap_down: assert property (p_wrap_down)
    else $error("down count did not wrap to all ones");

  // the illegal pair is kept deterministic rather than flagged
  property p_both_hold;
    @(posedge i_clk) disable iff (i_rst)
      !i_clear && !i_load && i_count_up_enable && i_count_down_enable
      |=> $stable(count_q) && $stable(o_all_ones_flag);
  endproperty
  a_both_hold: assert property (p_both_hold)
    else $error("count moved with both enables high");

endmodule // loadable_updown_counter

// File: pkg/updown_counter_pkg.sv
// updown_counter_pkg: shared types and constants for the up/down counter
// assumes a single 100 MHz clock domain with synchronous reset
package updown_counter_pkg;

  localparam int unsigned COUNT_WIDTH_DEF = 8;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // count value after reset and after clear
  localparam logic [0:0] COUNT_RESET_BIT = 1'h0;

  typedef enum logic [1:0] {
    OP_HOLD = 2'h0,
    OP_UP = 2'h1,
    OP_DOWN = 2'h2,
    OP_LOAD = 2'h3
  } count_op_t;

  typedef struct packed {
    logic clear;
    logic load;
    logic count_up_enable;
    logic count_down_enable;
  } count_ctrl_t;

endpackage

// File: src/count_op_decode.sv
// count_op_decode: turns the control inputs into one counter operation
// assumes controls are synchronous to the counter clock
`timescale 1ns/1ps
module count_op_decode
  import updown_counter_pkg::*;
(
  // controls
  input wire count_ctrl_t i_ctrl,
  // decoded operation
  output count_op_t o_op
);

  always_comb begin
    if (i_ctrl.load) begin
      o_op = OP_LOAD;
    end else if (i_ctrl.count_up_enable && !i_ctrl.count_down_enable) begin
      o_op = OP_UP;
    end else if (i_ctrl.count_down_enable && !i_ctrl.count_up_enable) begin
      o_op = OP_DOWN;
    end else begin
      // both low holds; both high also holds for determinism
      o_op = OP_HOLD;
    end
  end

endmodule // count_op_decode

// File: dv/ctrl_source.sv
// ctrl_source: user logic that drives the counter controls
// assumes the bench gives raw wishes off the clock edge
`timescale 1ns/1ps
module ctrl_source
  import updown_counter_pkg::*;
(
  // raw wish and leave to break the enable rule
  input wire count_ctrl_t i_want,
  input wire logic i_allow_both,
  // controls toward the counter
  output count_ctrl_t o_ctrl
);
  always_comb begin
    o_ctrl = i_want;
    // drop down enable so both never meet without clear or load, unless a scenario asks
    if (!i_allow_both && !i_want.clear && !i_want.load) begin
      o_ctrl.count_down_enable = i_want.count_down_enable &
        ~i_want.count_up_enable;
    end
  end
endmodule // ctrl_source

// File: dv/loadable_updown_counter_test.sv
// loadable_updown_counter_test: self-checking bench for the counter
// assumes 100 MHz clock, sync reset, controls from ctrl_source
`timescale 1ns/1ps
module loadable_updown_counter_test;
  import updown_counter_pkg::*;
  localparam int unsigned W = COUNT_WIDTH_DEF;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  count_ctrl_t want = '0;
  count_ctrl_t ctrl;
  logic allow = 1'b0;
  logic [W-1:0] data = '0;
  logic [W-1:0] count;
  logic ones;
  logic zeros;
  logic [W-1:0] exp = '0;
  int errors = 0;
  int comparisons = 0;
  always #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;
  ctrl_source SRC (.i_want(want), .i_allow_both(allow), .o_ctrl(ctrl));
  loadable_updown_counter #(.WIDTH(W)) DUT (.i_clk(i_clk),
    .i_rst(i_rst), .i_clear(ctrl.clear), .i_load(ctrl.load),
    .i_count_up_enable(ctrl.count_up_enable),
    .i_count_down_enable(ctrl.count_down_enable), .i_load_data(data),
    .o_count(count), .o_all_ones_flag(ones), .o_all_zeros_flag(zeros));
  function automatic logic [W-1:0] next_count(logic [W-1:0] q,
    count_ctrl_t c, logic [W-1:0] d);
    if (c.clear) return '0;
    if (c.load) return d;
    if (c.count_up_enable && !c.count_down_enable) return q + 1'b1;
    if (c.count_down_enable && !c.count_up_enable) return q - 1'b1;
    return q;
  endfunction
  task automatic end_of_test();
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check();
    comparisons += 3;
    if (count !== exp) begin
      errors++;
      $display("BAD count exp %h seen %h", exp, count);
    end
    if (ones !== (&exp)) begin
      errors++;
      $display("BAD all_ones_flag exp %b seen %b", &exp, ones);
    end
    if (zeros !== (~|exp)) begin
      errors++;
      $display("BAD all_zeros_flag exp %b seen %b", ~|exp, zeros);
    end
  endtask
  // checks the previous step, then drives the next one
  task automatic step(count_ctrl_t c, logic [W-1:0] d, logic a);
    @(negedge i_clk);
    check();
    want = c;
    data = d;
    allow = a;
    #1 exp = next_count(exp, ctrl, data);
  endtask
  initial begin
    void'($urandom(32'h2456FA21));
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    step(4'h0, 8'h00, 1'b0);
    step(4'h4, 8'hFE, 1'b0);
    step(4'h2, 8'h00, 1'b0);
    step(4'h2, 8'h00, 1'b0);
    step(4'h1, 8'h00, 1'b0);
    step(4'h3, 8'h00, 1'b1);
    step(4'h0, 8'h00, 1'b0);
    step(4'hE, 8'h55, 1'b0);
    step(4'h7, 8'hFF, 1'b1);
    step(4'hF, 8'hFF, 1'b1);
    step(4'h4, 8'h01, 1'b0);
    step(4'h1, 8'h00, 1'b0);
    repeat (400) begin
      step(count_ctrl_t'(4'($urandom_range(0, 15))), W'($urandom),
        1'($urandom_range(0, 1)));
    end
    // a reset in mid-run must beat a pending up count
    step(4'h2, 8'h00, 1'b0);
    @(negedge i_clk);
    check();
    i_rst = 1'b1;
    exp = '0;
    repeat (2) @(negedge i_clk);
    check();
    i_rst = 1'b0;
    #1 exp = next_count(exp, ctrl, data);
    step(4'h0, 8'h00, 1'b0);
    @(negedge i_clk);
    check();
    end_of_test();
  end
  // run needs about 420 cycles
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
endmodule // loadable_updown_counter_test
